// File: hw/cul_pkg.sv
package cul_pkg;
	// ----------------------------------------
	// measurement formats
	// ----------------------------------------
	localparam int PH_W = 16;
	localparam int REL_W = 18;
	localparam int DIFF_W = 19;
	localparam int REL_LSB = 15;
	localparam int CNT_W = 8;
	localparam int NUM_CLASSES = 6;
	// tan(30 deg) as NUM/DEN for the sector boundary
	localparam logic [31:0] TAN_NUM = 32'h0000_0400;
	localparam logic [31:0] TAN_DEN = 32'h0000_06EE;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int STEP_MS = 10;
	localparam int TICK_CYCLES = (CLK_HZ / 1000) * STEP_MS;
	localparam int OP_MIN_MS = 40;
	localparam int OP_MAX_MS = 300_000;
	localparam int OP_W = 15;
	localparam logic [OP_W-1:0] OP_MIN_STEPS = OP_W'(OP_MIN_MS / STEP_MS);
	localparam logic [OP_W-1:0] OP_MAX_STEPS = OP_W'(OP_MAX_MS / STEP_MS);

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
	localparam logic [OP_W-1:0] TIMER_RST = 15'h0000;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic signed [PH_W-1:0] re;
		logic signed [PH_W-1:0] im;
	} cul_phasor_t;

	typedef struct packed {
		logic signed [REL_W-1:0] re;
		logic signed [REL_W-1:0] im;
	} cul_rel_t;

	typedef struct packed {
		logic start;
		logic trip;
	} cul_stage_out_t;

	typedef enum logic {MODE_COMPENSATE, MODE_LOCATION} cul_mode_t;

	// sectors in clockwise order from 0 deg: 0, -60, -120, 180, +120, +60
	typedef enum logic [2:0] {SEC_P1B1, SEC_P3B2, SEC_P2B1, SEC_P1B2, SEC_P3B1, SEC_P2B2}
		cul_sector_t;

	function automatic logic [2*DIFF_W-1:0] mag2(input logic signed [DIFF_W-1:0] re,
		input logic signed [DIFF_W-1:0] im);
		logic signed [2*DIFF_W-1:0] r2;
		logic signed [2*DIFF_W-1:0] i2;
		r2 = re * re;
		i2 = im * im;
		return (2*DIFF_W)'(r2) + (2*DIFF_W)'(i2);
	endfunction
endpackage

// File: hw/cul_sector.sv
`timescale 1ns/1ns
module cul_sector (
	input wire logic signed [18:0] deltaRe, // compensated unbalance, real part
	input wire logic signed [18:0] deltaIm, // compensated unbalance, imaginary part
	output cul_pkg::cul_sector_t sector // branch and phase class
);
	logic [18:0] absRe;
	logic [18:0] absIm;
	logic nearAxis;

	// ----------------------------------------
	// angle class relative to phase-one current
	// ----------------------------------------
	always_comb begin
		absRe = deltaRe[18] ? 19'(-deltaRe) : 19'(deltaRe);
		absIm = deltaIm[18] ? 19'(-deltaIm) : 19'(deltaIm);
		// within 30 deg of the real axis when |im|/|re| < tan 30
		nearAxis = (32'(absIm) * cul_pkg::TAN_DEN) < (32'(absRe) * cul_pkg::TAN_NUM);
		if (nearAxis) begin
			sector = deltaRe[18] ? cul_pkg::SEC_P1B2 : cul_pkg::SEC_P1B1;
		end else if (!deltaRe[18]) begin
			// leading by 60 deg is phase 2 of branch 2
			sector = deltaIm[18] ? cul_pkg::SEC_P3B2 : cul_pkg::SEC_P2B2;
		end else begin
			sector = deltaIm[18] ? cul_pkg::SEC_P2B1 : cul_pkg::SEC_P3B1;
		end
	end
endmodule // cul_sector

// File: hw/cul_op_timer.sv
`timescale 1ns/1ns
module cul_op_timer (
	input wire logic ref_clk, // 50 MHz clock
	input wire logic rst_n, // async reset, active low
	input wire logic tick, // one pulse per 10 ms
	input wire logic run, // start condition present
	input wire logic restart, // begin a fresh delay
	input wire logic [14:0] setting, // operate time in 10 ms steps
	output logic expired // delay has run out, level
);
	logic [14:0] limit;
	logic [14:0] cnt_reg;
	logic [14:0] cnt_next;
	logic expired_next;

	// ----------------------------------------
	// delay count
	// ----------------------------------------
	always_comb begin
		// settings outside the range are pulled to its ends
		if (setting < cul_pkg::OP_MIN_STEPS) begin
			limit = cul_pkg::OP_MIN_STEPS;
		end else if (setting > cul_pkg::OP_MAX_STEPS) begin
			limit = cul_pkg::OP_MAX_STEPS;
		end else begin
			limit = setting;
		end
		cnt_next = cnt_reg;
		if (!run || restart) begin
			cnt_next = cul_pkg::TIMER_RST;
		end else if (tick && cnt_reg < limit) begin
			cnt_next = cnt_reg + 15'h0001;
		end
		expired_next = run && !restart && (cnt_next >= limit);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= cul_pkg::TIMER_RST;
			expired <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			expired <= expired_next;
		end
	end

	property p_min_delay;
		@(posedge ref_clk) disable iff (!rst_n)
		expired |-> cnt_reg >= cul_pkg::OP_MIN_STEPS;
	endproperty
	a_min_delay: assert property (p_min_delay) else $error("operate delay shorter than minimum");
endmodule // cul_op_timer

// File: hw/cul_locator.sv
// Operation
// - save command records unbalance phasor against the phase-one reference phasor.
// - recorded natural unbalance is subtracted so compensated unbalance reads zero.
// - only the location stage locates; companion stage stays a compensated stage.
// - with location enabled, location stage delay recompensates instead of tripping.
// - recompensation of location stage leaves companion compensation untouched.
// - each failure is classified by angle and one of six counters increments.
// - with location enabled, location stage trips only when fault count exceeds the allowed limit.
// - above start value, locate branch and phase, store it, then recompensate.
// - unbalance leading the reference by 60 degrees is phase 2, branch 2.
// - a clear command zeroes all location counters.
// - a mode setting on the location stage enables location.
// - operate time spans 0.04 to 300 s in 0.01 s steps.
`timescale 1ns/1ns
module cul_locator #(
	parameter int TICK_CYCLES = cul_pkg::TICK_CYCLES
) (
	input wire logic ref_clk, // 50 MHz clock
	input wire logic rst_n, // async reset, active low
	input cul_pkg::cul_phasor_t residual_input_one, // unbalance current phasor
	input cul_pkg::cul_phasor_t phase_one_current, // polarizing reference phasor
	input wire logic measValid, // one-cycle strobe, both phasors fresh
	input cul_pkg::cul_mode_t compensation_mode_setting, // location stage mode
	input wire logic save_balance_command, // one-cycle pulse, capture natural unbalance
	input wire logic clearCounters, // one-cycle pulse, zero location counters
	input wire logic [15:0] startValueA, // companion stage start level
	input wire logic [15:0] startValueB, // location stage start level
	input wire logic [14:0] opTimeA, // companion operate time, 10 ms steps
	input wire logic [14:0] opTimeB, // location operate time, 10 ms steps
	input wire logic [7:0] maxFaults, // allowed failed elements
	output cul_pkg::cul_stage_out_t stageA, // companion start and trip
	output cul_pkg::cul_stage_out_t stageB, // location start and trip
	output logic locEvent, // one-cycle pulse per located fault
	output cul_pkg::cul_sector_t lastSector, // class of the latest fault
	output logic [7:0] faultTotal, // faults since last clear
	output logic [5:0][7:0] faultCounts // per branch and phase counters
);
	localparam int TW = $clog2(TICK_CYCLES);

	// ----------------------------------------
	// 10 ms tick divider
	// ----------------------------------------
	logic [TW-1:0] div_reg;
	logic [TW-1:0] div_next;
	logic tick_reg;
	logic tick_next;

	always_comb begin
		tick_next = (div_reg == TW'(TICK_CYCLES - 1));
		div_next = tick_next ? '0 : div_reg + TW'(1);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			tick_reg <= tick_next;
		end
	end

	// ----------------------------------------
	// unbalance relative to phase-one current
	// ----------------------------------------
	// rotating by the reference makes the stored balance immune to frequency drift
	cul_pkg::cul_rel_t rel_reg;
	cul_pkg::cul_rel_t rel_next;
	logic relValid_reg;
	logic signed [32:0] prodRe;
	logic signed [32:0] prodIm;

	always_comb begin
		prodRe = 33'(residual_input_one.re * phase_one_current.re)
			+ 33'(residual_input_one.im * phase_one_current.im);
		prodIm = 33'(residual_input_one.im * phase_one_current.re)
			- 33'(residual_input_one.re * phase_one_current.im);
		rel_next = rel_reg;
		if (measValid) begin
			rel_next.re = prodRe[32:cul_pkg::REL_LSB];
			rel_next.im = prodIm[32:cul_pkg::REL_LSB];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rel_reg <= '0;
			relValid_reg <= 1'b0;
		end else begin
			rel_reg <= rel_next;
			relValid_reg <= measValid;
		end
	end

	// ----------------------------------------
	// compensation and start detection
	// ----------------------------------------
	cul_pkg::cul_rel_t balA_reg;
	cul_pkg::cul_rel_t balB_reg;
	logic signed [18:0] compARe;
	logic signed [18:0] compAIm;
	logic signed [18:0] compBRe;
	logic signed [18:0] compBIm;
	logic expA;
	logic expB;
	cul_pkg::cul_sector_t sector;

	always_comb begin
		compARe = 19'(rel_reg.re) - 19'(balA_reg.re);
		compAIm = 19'(rel_reg.im) - 19'(balA_reg.im);
		compBRe = 19'(rel_reg.re) - 19'(balB_reg.re);
		compBIm = 19'(rel_reg.im) - 19'(balB_reg.im);
	end

	cul_sector u_sector (
		.deltaRe(compBRe),
		.deltaIm(compBIm),
		.sector(sector)
	);

	cul_op_timer u_timer_a (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.tick(tick_reg),
		.run(stageA.start),
		.restart(1'b0),
		.setting(opTimeA),
		.expired(expA)
	);

	cul_op_timer u_timer_b (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.tick(tick_reg),
		.run(stageB.start),
		.restart(locEvent),
		.setting(opTimeB),
		.expired(expB)
	);

	// ----------------------------------------
	// stage state, location and counters
	// ----------------------------------------
	cul_pkg::cul_rel_t balA_next;
	cul_pkg::cul_rel_t balB_next;
	cul_pkg::cul_stage_out_t stageA_next;
	cul_pkg::cul_stage_out_t stageB_next;
	logic locEvent_next;
	cul_pkg::cul_sector_t lastSector_next;
	logic [7:0] faultTotal_next;
	logic [5:0][7:0] faultCounts_next;
	logic locate;

	always_comb begin
		balA_next = balA_reg;
		balB_next = balB_reg;
		stageA_next = stageA;
		stageB_next = stageB;
		lastSector_next = lastSector;
		faultTotal_next = faultTotal;
		faultCounts_next = faultCounts;
		if (save_balance_command) begin
			balA_next = rel_reg;
			balB_next = rel_reg;
		end
		if (relValid_reg) begin
			stageA_next.start = cul_pkg::mag2(compARe, compAIm)
				> 38'(startValueA * startValueA);
			stageB_next.start = cul_pkg::mag2(compBRe, compBIm)
				> 38'(startValueB * startValueB);
		end
		// companion stage is a plain compensated stage in every mode
		stageA_next.trip = stageA.start && expA;
		// location only when the mode setting selects it
		locate = (compensation_mode_setting == cul_pkg::MODE_LOCATION)
			&& stageB.start && expB && !locEvent;
		if (compensation_mode_setting == cul_pkg::MODE_COMPENSATE) begin
			stageB_next.trip = stageB.start && expB;
		end
		// clear first so a fault in the same cycle still counts
		if (clearCounters) begin
			faultCounts_next = '0;
			faultTotal_next = cul_pkg::CNT_RST;
			stageB_next.trip = 1'b0;
		end
		if (locate) begin
			lastSector_next = sector;
			if (faultCounts_next[sector] != 8'hFF) begin
				faultCounts_next[sector] = faultCounts_next[sector] + 8'h01;
			end
			if (faultTotal_next != 8'hFF) begin
				faultTotal_next = faultTotal_next + 8'h01;
			end
			// trip only once the limit is passed
			if (faultTotal_next > maxFaults) begin
				stageB_next.trip = 1'b1;
			end
			// only the location stage balance moves
			balB_next = rel_reg;
			stageB_next.start = 1'b0;
		end
		locEvent_next = locate;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			balA_reg <= '0;
			balB_reg <= '0;
			stageA <= '0;
			stageB <= '0;
			locEvent <= 1'b0;
			lastSector <= cul_pkg::SEC_P1B1;
			faultTotal <= cul_pkg::CNT_RST;
			faultCounts <= '0;
		end else begin
			balA_reg <= balA_next;
			balB_reg <= balB_next;
			stageA <= stageA_next;
			stageB <= stageB_next;
			locEvent <= locEvent_next;
			lastSector <= lastSector_next;
			faultTotal <= faultTotal_next;
			faultCounts <= faultCounts_next;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_located;
		locEvent ##0 !$past(clearCounters);
	endsequence

	property p_save_capture;
		save_balance_command && !locate |=> balA_reg == $past(rel_reg) && balB_reg == balA_reg;
	endproperty
	a_save_capture: assert property (p_save_capture) else $error("balance not captured");

	property p_comp_zero;
		relValid_reg && rel_reg == balB_reg |=> !stageB.start;
	endproperty
	a_comp_zero: assert property (p_comp_zero) else $error("compensated unbalance not zero");

	property p_comp_zero_a;
		relValid_reg && rel_reg == balA_reg |=> !stageA.start;
	endproperty
	a_comp_zero_a: assert property (p_comp_zero_a) else $error("companion not compensated");

	property p_only_location;
		compensation_mode_setting == cul_pkg::MODE_COMPENSATE |=> !locEvent;
	endproperty
	a_only_location: assert property (p_only_location) else $error("location outside mode");

	property p_companion_trip;
		stageA.trip |-> $past(stageA.start);
	endproperty
	a_companion_trip: assert property (p_companion_trip) else $error("companion trip without start");

	property p_recomp;
		locEvent |-> balB_reg == $past(rel_reg) && !stageB.start;
	endproperty
	a_recomp: assert property (p_recomp) else $error("no recompensation");

	property p_companion_kept;
		locEvent && !$past(save_balance_command) |-> $stable(balA_reg);
	endproperty
	a_companion_kept: assert property (p_companion_kept) else $error("companion moved");

	property p_count_step;
		s_located ##0 $past(faultTotal) != 8'hFF |-> faultTotal == $past(faultTotal) + 8'h01;
	endproperty
	a_count_step: assert property (p_count_step) else $error("fault count not advanced");

	property p_trip_limit;
		s_located |-> stageB.trip == (faultTotal > maxFaults || $past(stageB.trip));
	endproperty
	a_trip_limit: assert property (p_trip_limit) else $error("trip against limit");

	property p_trip_latched;
		compensation_mode_setting == cul_pkg::MODE_LOCATION && stageB.trip && !clearCounters
			|=> stageB.trip;
	endproperty
	a_trip_latched: assert property (p_trip_latched) else $error("location trip dropped");

	property p_start_first;
		locEvent |-> $past(stageB.start) && $past(expB);
	endproperty
	a_start_first: assert property (p_start_first) else $error("location without start");

	property p_sector_60;
		compBRe > 19'sh00100 && compBIm * 1024 > compBRe * 1500 && compBIm * 1024 < compBRe * 2000
			|-> sector == cul_pkg::SEC_P2B2;
	endproperty
	a_sector_60: assert property (p_sector_60) else $error("60 deg lead misclassified");

	property p_clear;
		clearCounters && !locate |=> faultTotal == 8'h00 && faultCounts == '0 && !stageB.trip;
	endproperty
	a_clear: assert property (p_clear) else $error("counters not cleared");
endmodule // cul_locator

// File: verification/cul_meas_model.sv
`timescale 1ns/1ns
module cul_meas_model (
	input wire logic ref_clk, // bench clock
	input wire logic rst_n, // reset sampled on the falling clock edge, active low
	input cul_pkg::cul_phasor_t unbal, // unbalance phasor to present
	input cul_pkg::cul_phasor_t refPh, // reference phasor to present
	output cul_pkg::cul_phasor_t residual_input_one, // to design
	output cul_pkg::cul_phasor_t phase_one_current, // to design
	output logic measValid // one-cycle strobe
);
	logic [2:0] phaseCnt;
	logic fresh;
	assign fresh = rst_n && (phaseCnt == 3'h7);
	// ----------------------------------------
	// one strobe every eight cycles
	// ----------------------------------------
	always @(negedge ref_clk) begin
		phaseCnt <= rst_n ? phaseCnt + 3'h1 : 3'h0;
		measValid <= fresh;
		// between strobes the lines carry garbage, never the held value
		residual_input_one <= fresh ? unbal : ~unbal;
		phase_one_current <= fresh ? refPh : ~refPh;
	end
endmodule // cul_meas_model

// File: verification/tb_capacitor_unbalance_locator.sv
`timescale 1ns/1ns
module tb_capacitor_unbalance_locator;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	cul_pkg::cul_phasor_t unbal;
	cul_pkg::cul_phasor_t refPh;
	cul_pkg::cul_phasor_t resIn;
	cul_pkg::cul_phasor_t refIn;
	logic measValid;
	cul_pkg::cul_mode_t mode;
	logic save;
	logic clr;
	logic [14:0] opA;
	logic [14:0] opB;
	logic [7:0] maxF;
	cul_pkg::cul_stage_out_t stA;
	cul_pkg::cul_stage_out_t stB;
	logic locEv;
	cul_pkg::cul_sector_t lastSec;
	logic [7:0] total;
	logic [5:0][7:0] counts;
	int fail_count = 0;
	int comparisons = 0;
	int events = 0;
	int k;
	int n;
	int e0;
	logic [7:0] lfsr = 8'h0F;
	logic [7:0] expCnt [6];
	logic [7:0] expTotal;
	// one faulty element per sector, 60 degree steps, same order as the sector codes
	logic signed [15:0] dRe [6] = '{16'h0FA0, 16'h07D0, 16'hF830, 16'hF060, 16'hF830, 16'h07D0};
	logic signed [15:0] dIm [6] = '{16'h0000, 16'hF278, 16'hF278, 16'h0000, 16'h0D88, 16'h0D88};

	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (locEv === 1'b1) begin
			events++;
		end
	end

	cul_meas_model i_model (.ref_clk(ref_clk), .rst_n(rst_n), .unbal(unbal), .refPh(refPh),
		.residual_input_one(resIn), .phase_one_current(refIn), .measValid(measValid));

	cul_locator #(.TICK_CYCLES(10)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.residual_input_one(resIn), .phase_one_current(refIn), .measValid(measValid),
		.compensation_mode_setting(mode), .save_balance_command(save), .clearCounters(clr),
		.startValueA(16'h0100), .startValueB(16'h0100), .opTimeA(opA), .opTimeB(opB),
		.maxFaults(maxF), .stageA(stA), .stageB(stB), .locEvent(locEv), .lastSector(lastSec),
		.faultTotal(total), .faultCounts(counts));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function automatic logic exp_trip(input logic [7:0] t, input logic [7:0] m);
		return t > m;
	endfunction
	task automatic stop_test();
		if (fail_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: flag %b, want %b", $time, got, exp);
		end
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: field %h, want %h", $time, got, exp);
		end
	endtask
	task automatic wait_loc(output int cyc);
		cyc = 0;
		@(negedge ref_clk);
		while (locEv !== 1'b1 && cyc < 400) begin
			@(negedge ref_clk);
			cyc++;
		end
		if (locEv !== 1'b1) begin
			fail_count++;
			$display("wrong value at %0t: no located fault", $time);
			stop_test();
		end
	endtask
	// save only well clear of a strobe, the capture takes the held relative phasor
	task automatic save_bal();
		n = 0;
		while (measValid !== 1'b1 && n < 20) begin
			@(posedge ref_clk);
			n++;
		end
		if (measValid !== 1'b1) begin
			fail_count++;
			$display("wrong value at %0t: no measurement strobe", $time);
			stop_test();
		end
		repeat (3) @(negedge ref_clk);
		save <= 1'b1;
		@(negedge ref_clk);
		save <= 1'b0;
		repeat (24) @(negedge ref_clk);
	endtask
	task automatic inject(input int s);
		@(negedge ref_clk);
		unbal.re <= unbal.re + dRe[s];
		unbal.im <= unbal.im + dIm[s];
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		unbal = {16'h03E8, 16'h0258};
		refPh = {16'h4000, 16'h0000};
		mode = cul_pkg::MODE_COMPENSATE;
		save = 1'b0;
		clr = 1'b0;
		opA = 15'h0004;
		opB = 15'h0001;
		maxF = 8'h03;
		expTotal = 8'h00;
		foreach (expCnt[i]) expCnt[i] = 8'h00;
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		chk8(total, 8'h00);
		repeat (24) @(negedge ref_clk);
		chk1(stA.start, 1'b1);
		mode <= cul_pkg::MODE_LOCATION;
		save_bal();
		chk1(stA.start, 1'b0);
		chk1(stB.start, 1'b0);
		for (int f = 0; f < 4; f++) begin
			// first fault is the 60 degree lead case, the rest are random sectors
			k = (f == 0) ? 5 : int'(lfsr % 8'h06);
			lfsr = lfsr_next(lfsr);
			inject(k);
			wait_loc(n);
			if (f == 0) chk1(n >= 30, 1'b1);
			expCnt[k] = expCnt[k] + 8'h01;
			expTotal = expTotal + 8'h01;
			chk8({5'h00, lastSec}, 8'(k));
			chk8(counts[k], expCnt[k]);
			chk8(total, expTotal);
			repeat (70) @(negedge ref_clk);
			chk1(stB.start, 1'b0);
			chk8(8'(events), expTotal);
			chk1(stB.trip, exp_trip(expTotal, maxF));
			chk1(stA.start, 1'b1);
			chk1(stA.trip, 1'b1);
		end
		clr <= 1'b1;
		@(negedge ref_clk);
		clr <= 1'b0;
		repeat (3) @(negedge ref_clk);
		chk8(total, 8'h00);
		chk1(stB.trip, 1'b0);
		for (int i = 0; i < 6; i++) chk8(counts[i], 8'h00);
		mode <= cul_pkg::MODE_COMPENSATE;
		save_bal();
		e0 = events;
		inject(0);
		repeat (120) @(negedge ref_clk);
		chk1(stB.trip, 1'b1);
		chk1(events == e0, 1'b1);
		chk8(total, 8'h00);
		stop_test();
	end
endmodule // tb_capacitor_unbalance_locator
